// *** hdl/cdc_conversion_sequencer.sv ***
// Conversion sequencer: stage timing, power modes, offsets, raw result.
// Assumes converter, touch and button inputs come from same-clock logic.
`default_nettype none
module cdc_conversion_sequencer #(
   parameter int STAGE128_CYC = cdc_seq_pkg::STAGE128_CYC,
   parameter int STAGE256_CYC = cdc_seq_pkg::STAGE256_CYC,
   parameter int SLEEP_UNIT_CYC = cdc_seq_pkg::SLEEP_UNIT_CYC,
   parameter int TOUCH_PERIOD_CYC = cdc_seq_pkg::TOUCH_PERIOD_CYC,
   parameter int FIFO_DEPTH = cdc_seq_pkg::FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [15:0] i_ctrl_reg,
   input wire logic [3:0] i_last_stage,
   input wire logic i_offset_we,
   input wire logic [3:0] i_offset_stage,
   input wire logic [6:0] i_plus_offset_dac,
   input wire logic [6:0] i_minus_offset_dac,
   input wire logic [15:0] i_conv_data,
   input wire logic i_touched,
   input wire logic i_pair_side_a,
   input wire logic i_pair_side_b,
   output logic o_conv_start,
   output logic [3:0] o_stage_index,
   output logic o_busy,
   output logic [6:0] o_plus_offset_dac,
   output logic [6:0] o_minus_offset_dac,
   output logic o_plus_to_negative,
   output logic o_minus_to_negative,
   output logic [15:0] o_raw_converter_result,
   output logic o_button_a,
   output logic o_button_b,
   output logic o_result_valid,
   input wire logic i_result_ready,
   output logic [19:0] o_result_data
);
   typedef enum logic [1:0] {IDLE, CONVERT, PUSH, SLEEP} seq_state_type;
   typedef struct packed {
      seq_state_type fsm;
      logic [3:0] stage;
      logic [31:0] cnt;
      logic conv_start;
      logic [15:0] held;
      logic [15:0] raw;
      logic [11:0][6:0] plus_tab;
      logic [11:0][6:0] minus_tab;
      logic btn_a;
      logic btn_b;
   } seq_type;
   seq_type state_reg;
   seq_type state_next;
   logic [1:0] power_mode;
   logic [1:0] sleep_interval_select;
   logic [1:0] decim;
   logic running;
   logic low_power;
   logic [3:0] last_eff;
   logic [31:0] stage_cyc;
   logic [31:0] sleep_cyc;
   logic fifo_ready;
   logic push_fire;

   // Control field decode
   assign power_mode = i_ctrl_reg[cdc_seq_pkg::POWER_LSB +: 2];
   // RULE6: delay field position
   assign sleep_interval_select = i_ctrl_reg[cdc_seq_pkg::SLEEP_LSB +: 2];
   assign decim = i_ctrl_reg[cdc_seq_pkg::DECIM_LSB +: 2];
   // RULE16: full or low power run, rest shutdown
   assign low_power = (power_mode == cdc_seq_pkg::POWER_LOW);
   assign running = (power_mode == cdc_seq_pkg::POWER_FULL) || low_power;
   // RULE1: at most twelve stages
   assign last_eff = (i_last_stage > cdc_seq_pkg::LAST_STAGE_MAX)
      ? cdc_seq_pkg::LAST_STAGE_MAX : i_last_stage;
   // RULE15: oversampling selects stage time
   // RULE4: stage time per decimation
   assign stage_cyc = (decim == cdc_seq_pkg::DECIM_128)
      ? 32'(STAGE128_CYC) : 32'(STAGE256_CYC);
   // RULE7: delay from code
   // RULE17: touched uses short period
   assign sleep_cyc = i_touched ? 32'(TOUCH_PERIOD_CYC)
      : 32'(SLEEP_UNIT_CYC) * (32'(sleep_interval_select) + 32'h00000001);
   assign push_fire = (state_reg.fsm == PUSH) && fifo_ready;

   always_comb
   begin
      state_next = state_reg;
      state_next.conv_start = 1'b0;
      // RULE12: both pressed means neither
      state_next.btn_a = i_pair_side_a && !i_pair_side_b;
      state_next.btn_b = i_pair_side_b && !i_pair_side_a;
      // RULE8: per-stage offset storage
      if (i_offset_we && (i_offset_stage <= cdc_seq_pkg::LAST_STAGE_MAX))
      begin
         state_next.plus_tab[i_offset_stage] = i_plus_offset_dac;
         state_next.minus_tab[i_offset_stage] = i_minus_offset_dac;
      end
      case (state_reg.fsm)
         IDLE, SLEEP:
         begin
            // RULE18: no start in shutdown
            if (!running)
            begin
               state_next.fsm = IDLE;
            end
            // RULE2: always begin at stage zero
            else if (state_reg.fsm == IDLE || state_reg.cnt == '0)
            begin
               state_next.fsm = CONVERT;
               state_next.stage = 4'h0;
               state_next.cnt = stage_cyc - 32'h00000002;
               state_next.conv_start = 1'b1;
            end
            else
            begin
               state_next.cnt = state_reg.cnt - 32'h00000001;
            end
         end
         CONVERT:
         begin
            if (!running)
            begin
               state_next.fsm = IDLE;
            end
            else if (state_reg.cnt == '0)
            begin
               state_next.fsm = PUSH;
               state_next.held = i_conv_data;
            end
            else
            begin
               state_next.cnt = state_reg.cnt - 32'h00000001;
            end
         end
         PUSH:
         begin
            if (!running)
            begin
               state_next.fsm = IDLE;
            end
            else if (fifo_ready)
            begin
               // RULE11: raw result update
               state_next.raw = state_reg.held;
               // RULE2: advance in order to last stage
               if (state_reg.stage < last_eff)
               begin
                  state_next.fsm = CONVERT;
                  state_next.stage = state_reg.stage + 4'h1;
                  state_next.cnt = stage_cyc - 32'h00000002;
                  state_next.conv_start = 1'b1;
               end
               // RULE5: low power sleeps after sequence
               else if (low_power)
               begin
                  state_next.fsm = SLEEP;
                  state_next.cnt = sleep_cyc - 32'h00000001;
               end
               else
               begin
                  state_next.fsm = CONVERT;
                  state_next.stage = 4'h0;
                  state_next.cnt = stage_cyc - 32'h00000002;
                  state_next.conv_start = 1'b1;
               end
            end
         end
         default:
         begin
            state_next.fsm = IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   result_fifo #(
      .WIDTH(20),
      .DEPTH(FIFO_DEPTH)
   ) u_result_fifo (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_in_valid(state_reg.fsm == PUSH),
      .o_in_ready(fifo_ready),
      .i_in_data({state_reg.stage, state_reg.held}),
      .o_out_valid(o_result_valid),
      .i_out_ready(i_result_ready),
      .o_out_data(o_result_data)
   );

   assign o_conv_start = state_reg.conv_start;
   assign o_stage_index = state_reg.stage;
   assign o_busy = (state_reg.fsm == CONVERT) || (state_reg.fsm == PUSH);
   assign o_raw_converter_result = state_reg.raw;
   assign o_plus_offset_dac = state_reg.plus_tab[state_reg.stage];
   assign o_minus_offset_dac = state_reg.minus_tab[state_reg.stage];
   // RULE9: top field bit picks input
   assign o_plus_to_negative = state_reg.plus_tab[state_reg.stage][cdc_seq_pkg::ROUTE_BIT];
   assign o_minus_to_negative = state_reg.minus_tab[state_reg.stage][cdc_seq_pkg::ROUTE_BIT];
   assign o_button_a = state_reg.btn_a;
   assign o_button_b = state_reg.btn_b;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   chk_shutdown_start: assert property (!running |=> !o_conv_start) // RULE18
      else $error("sequence started in shutdown");
   chk_raw_stable: assert property (!push_fire |=> $stable(o_raw_converter_result)) // RULE11
      else $error("raw result changed without a stage end");
   chk_stage_bound: assert property (o_stage_index <= 4'hb) // RULE1
      else $error("stage index above eleven");
   chk_first_stage: assert property (
      $past(state_reg.fsm == IDLE || state_reg.fsm == SLEEP) && o_conv_start
      |-> o_stage_index == 4'h0) // RULE2
      else $error("sequence did not begin at stage zero");
   chk_stage_order: assert property (push_fire && running && state_reg.stage < last_eff
      |=> o_conv_start && o_stage_index == $past(state_reg.stage) + 4'h1) // RULE2
      else $error("stage did not advance by one");
   chk_stage_time: assert property (o_conv_start // RULE4
      |-> state_reg.cnt == $past(stage_cyc) - 32'h2)
      else $error("stage time count wrong");
   chk_sleep_length: assert property (
      push_fire && running && low_power && state_reg.stage >= last_eff
      |=> state_reg.fsm == SLEEP && state_reg.cnt == $past(sleep_cyc) - 32'h1) // RULE7
      else $error("sleep length wrong");
   chk_full_wrap: assert property (
      push_fire && power_mode == 2'h0 && state_reg.stage >= last_eff
      |=> o_conv_start && o_stage_index == 4'h0) // RULE5
      else $error("full power did not restart at once");
   chk_pair_exclusive: assert property (i_pair_side_a && i_pair_side_b
      |=> !o_button_a && !o_button_b) // RULE12
      else $error("both buttons of a pair reported");

   cov_full_seq: cover property (push_fire && state_reg.stage == last_eff && !low_power);
   cov_sleep: cover property (state_reg.fsm == SLEEP && state_reg.cnt == '0);
   cov_stall: cover property (state_reg.fsm == PUSH && !fifo_ready);
   cov_shutdown: cover property (o_busy ##1 !running);
endmodule : cdc_conversion_sequencer
`default_nettype wire

// *** hdl/cdc_seq_pkg.sv ***
// Constants for the conversion sequencer and its result buffer.
// Assumes a single 25 MHz clock shared by the converter and the host logic.
// Functional notes
// RULE1: One to twelve stages per sequence, each with its own offsets.
// RULE2: Sequence starts at stage zero, runs in order to the last-stage field.
// RULE3: Software writes last-stage field as stages used minus one.
// RULE4: Sequence lasts last-stage plus one stage times, 1.536 or 3.072 ms.
// RULE5: Low power: one full-length sequence, then the programmed delay.
// RULE6: Low-power delay code lives in control register bits 3 to 2.
// RULE7: Delay codes 00..11 give 200, 400, 600, 800 ms.
// RULE8: Two 7-bit offset fields per stage drive the offset DACs.
// RULE9: Each offset DAC routes to positive or negative converter input.
// RULE10: Software programs offset fields once, at characterisation.
// RULE11: Raw 16-bit converter result readable at address 0x00b.
// RULE12: Both buttons of a differential pair active means neither active.
// RULE13: Software gives a pair one stage, a slider or wheel eight.
// RULE14: Software sets calibration enables to match the stages used.
// RULE15: Control bits 9 to 8: 00 selects 256, 01 selects 128.
// RULE16: Power mode resets to full power; 10 low power; 01, 11 shutdown.
// RULE17: Low power with touch: a sequence every 36 ms instead; the code sleeps 36 ms after each sequence in place of the programmed delay.
// RULE18: Shutdown starts no sequence and leaves results unchanged.
`default_nettype none
package cdc_seq_pkg;
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] RAW_RESULT_ADDR = 12'h00b;
   localparam int POWER_LSB = 0;
   localparam int SLEEP_LSB = 2;
   localparam int DECIM_LSB = 8;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [1:0] POWER_FULL = 2'h0;
   localparam logic [1:0] POWER_LOW = 2'h2;
   localparam logic [1:0] DECIM_256 = 2'h0;
   localparam logic [1:0] DECIM_128 = 2'h1;
   localparam int MAX_STAGES = 12;
   localparam logic [3:0] LAST_STAGE_MAX = 4'hb;
   localparam int OFFSET_WIDTH = 7;
   localparam int ROUTE_BIT = 6;
   localparam int RESULT_WIDTH = 16;
   localparam int FIFO_DEPTH = 16;
   localparam longint CLK_PERIOD_NS = 40;
   localparam longint STAGE128_NS = 1536000;
   localparam longint STAGE256_NS = 3072000;
   localparam longint SLEEP_UNIT_NS = 200000000;
   localparam longint TOUCH_PERIOD_NS = 36000000;
   localparam int STAGE128_CYC = int'(STAGE128_NS / CLK_PERIOD_NS);
   localparam int STAGE256_CYC = int'(STAGE256_NS / CLK_PERIOD_NS);
   localparam int SLEEP_UNIT_CYC = int'(SLEEP_UNIT_NS / CLK_PERIOD_NS);
   localparam int TOUCH_PERIOD_CYC = int'(TOUCH_PERIOD_NS / CLK_PERIOD_NS);
endpackage : cdc_seq_pkg
`default_nettype wire

// *** hdl/result_fifo.sv ***
// First-in first-out buffer for stage results.
// Assumes one clock; both sides use valid and ready.
`default_nettype none
module result_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } fifo_state_type;
   fifo_state_type state_reg;
   fifo_state_type state_next;
   logic push;
   logic pop;

   assign o_in_ready = (state_reg.count != (AW+1)'(DEPTH));
   assign o_out_valid = (state_reg.count != '0);
   assign o_out_data = state_reg.mem[state_reg.rd_ptr];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   always_comb
   begin
      state_next = state_reg;
      if (push)
      begin
         state_next.mem[state_reg.wr_ptr] = i_in_data;
         state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
      end
      if (pop)
      begin
         state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
         state_next.count = state_reg.count + 1'b1;
      end
      else if (pop && !push)
      begin
         state_next.count = state_reg.count - 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   chk_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_rstn)
      state_reg.count <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule : result_fifo
`default_nettype wire

// *** tb/host_result_reader.sv ***
// Host model: pops result words from the sequencer's buffer.
// Assumes the bench drives a stall level to hold reads off.
`default_nettype none
module host_result_reader (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_stall,
   input wire logic i_valid,
   input wire logic [19:0] i_data,
   output logic o_ready,
   output logic [19:0] o_last_word,
   output var int o_pops
);
   timeunit 1ns;
   timeprecision 1ps;
   assign o_ready = ~i_stall;
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         o_pops <= 0;
         o_last_word <= 20'h00000;
      end
      else if (i_valid && o_ready)
      begin
         o_pops <= o_pops + 1;
         o_last_word <= i_data;
      end
   end
endmodule : host_result_reader
`default_nettype wire

// *** tb/cdc_conversion_sequencer_tb_top.sv ***
// Bench for the conversion sequencer with shortened stage and sleep counts.
// Assumes the host model pops results whenever it is not stalled.
`default_nettype none
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
   $display("CHECK FAILED t=%0t %s", $time, m); end end
module cdc_conversion_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, we, touched, pa, pb, stall;
   logic start, busy, pneg, mneg, ba, bb, rvalid, rready;
   logic [15:0] ctrl, conv, raw, raw0;
   logic [3:0] last, ostage, sidx;
   logic [6:0] pofs, mofs, pdac, mdac;
   logic [19:0] rdata, word;
   int pops, p0, n, c;
   int fail_count = 0;
   int comparisons = 0;
   cdc_conversion_sequencer #(.STAGE128_CYC(8), .STAGE256_CYC(16), .SLEEP_UNIT_CYC(20),
      .TOUCH_PERIOD_CYC(10), .FIFO_DEPTH(16)) u_cdc_conversion_sequencer (
      .i_clk(clk), .i_rstn(rstn), .i_ctrl_reg(ctrl), .i_last_stage(last),
      .i_offset_we(we), .i_offset_stage(ostage), .i_plus_offset_dac(pofs),
      .i_minus_offset_dac(mofs), .i_conv_data(conv), .i_touched(touched),
      .i_pair_side_a(pa), .i_pair_side_b(pb), .o_conv_start(start), .o_stage_index(sidx),
      .o_busy(busy), .o_plus_offset_dac(pdac), .o_minus_offset_dac(mdac),
      .o_plus_to_negative(pneg), .o_minus_to_negative(mneg),
      .o_raw_converter_result(raw), .o_button_a(ba), .o_button_b(bb),
      .o_result_valid(rvalid), .i_result_ready(rready), .o_result_data(rdata));
   host_result_reader u_host_result_reader (.i_clk(clk), .i_rstn(rstn), .i_stall(stall),
      .i_valid(rvalid), .i_data(rdata), .o_ready(rready), .o_last_word(word), .o_pops(pops));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic final_report;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report
   task automatic next_start(output int k);
      k = 0;
      do
      begin
         @(negedge clk);
         k++;
      end
      while (start !== 1'b1 && k < 3000);
   endtask : next_start
   task automatic count_starts(input int cyc, output int k);
      k = 0;
      repeat (cyc)
      begin
         @(negedge clk);
         if (start === 1'b1)
            k++;
      end
   endtask : count_starts
   task automatic run_gaps(input int cnt, input int exp);
      int k;
      next_start(k);
      next_start(k);
      for (int i = 0; i < cnt; i++)
      begin
         next_start(k);
         `CHK(k, exp, "start spacing")
      end
   endtask : run_gaps
   task automatic wrap_check(input logic [3:0] top);
      int k;
      int m;
      m = 0;
      do
      begin
         next_start(k);
         m++;
      end
      while (sidx !== top && m < 20);
      `CHK(sidx, top, "last stage reached")
      next_start(k);
      `CHK(sidx, 4'h0, "wrap to stage zero")
   endtask : wrap_check
   initial
   begin
      #(40 * 20000);
      fail_count++;
      final_report();
   end
   initial
   begin
      rstn = 1'b0;
      ctrl = 16'h0101;
      last = 4'h2;
      we = 1'b0;
      ostage = 4'h0;
      pofs = 7'h00;
      mofs = 7'h00;
      conv = 16'hbeef;
      touched = 1'b0;
      pa = 1'b0;
      pb = 1'b0;
      stall = 1'b0;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      we = 1'b1;
      ostage = 4'h1;
      pofs = 7'h45;
      mofs = 7'h12;
      @(negedge clk);
      we = 1'b0;
      ctrl = 16'h0100;
      for (int i = 0; i < 6; i++)
      begin
         next_start(n);
         `CHK(sidx, 4'(i % 3), "stage order")
         `CHK(busy, 1'b1, "busy in stage")
         if (i > 0)
            `CHK(n, 8, "stage time 128")
         if (i == 4)
         begin
            `CHK(pdac, 7'h45, "plus offset")
            `CHK(mdac, 7'h12, "minus offset")
            `CHK({pneg, mneg}, 2'b10, "offset routing")
         end
      end
      @(negedge clk);
      `CHK(word, {4'h1, 16'hbeef}, "result word")
      `CHK(raw, 16'hbeef, "raw result")
      $display("test full_power done");
      ctrl = 16'h0000;
      run_gaps(3, 16);
      ctrl = 16'h0200;
      run_gaps(1, 16);
      $display("test decimation done");
      last = 4'h0;
      for (int code = 0; code < 4; code++)
      begin
         ctrl = {6'h00, 2'h1, 4'h0, 2'(code), 2'h2};
         run_gaps(1, 8 + (code + 1) * 20);
      end
      touched = 1'b1;
      run_gaps(1, 18);
      touched = 1'b0;
      $display("test low_power done");
      for (int i = 0; i < 4; i++)
      begin
         {pa, pb} = 2'(i);
         repeat (2) @(negedge clk);
         `CHK({ba, bb}, {pa & ~pb, pb & ~pa}, "pair buttons")
      end
      $display("test buttons done");
      ctrl = 16'h0100;
      last = 4'h7;
      wrap_check(4'h7);
      last = 4'hf;
      wrap_check(4'hb);
      $display("test stage_count done");
      last = 4'h2;
      stall = 1'b1;
      repeat (400) @(negedge clk);
      count_starts(40, c);
      `CHK(c, 0, "stage held while full")
      `CHK(rvalid, 1'b1, "buffer holds data")
      ctrl = 16'h0001;
      @(negedge clk);
      p0 = pops;
      raw0 = raw;
      stall = 1'b0;
      count_starts(40, c);
      `CHK(c, 0, "no start in shutdown")
      `CHK(pops - p0, 16, "drained word count")
      `CHK(rvalid, 1'b0, "buffer empty")
      ctrl = 16'h0003;
      count_starts(40, c);
      `CHK(c, 0, "no start in shutdown 11")
      `CHK(raw, raw0, "raw kept in shutdown")
      $display("test buffer_shutdown done");
      final_report();
   end
endmodule : cdc_conversion_sequencer_tb_top
`default_nettype wire
